// *** inc/sleep_ctl_cfg.svh ***
// Constants for the sleep mode power controller
`ifndef SLEEP_CTL_CFG_SVH
`define SLEEP_CTL_CFG_SVH

`define MODE_IDLE 3'h0
`define MODE_PDOWN 3'h2
`define MODE_PSAVE 3'h3
`define MODE_SBY 3'h6
`define MODE_XSBY 3'h7

`define SYS_CLK_MHZ 10
`define HOLD_CYCLES 16'h0004
`define SBY_WAKE_CYCLES 16'h0006
`define DLY0_CYCLES 16'h0102
`define DLY1_CYCLES 16'h0400
`define DLY2_CYCLES 16384
`define DLY3_TIME_US 4100
`define DLY3_CYCLES (`DLY3_TIME_US * `SYS_CLK_MHZ)

`define BROWNOUT_OFF_CODE 3'h7
`define PERIPH_N 8
`define WAKE_N 9

`endif

// *** inc/sleep_ctl_pkg.sv ***
// Types for the sleep mode power controller
package sleep_ctl_pkg;
	typedef enum logic [3:0] {
		ST_ACTIVE = 4'h1,
		ST_SLEEP = 4'h2,
		ST_START = 4'h4,
		ST_HOLD = 4'h8
	} pm_state_t;
endpackage : sleep_ctl_pkg

// *** rtl/sleep_mode_power_controller.sv ***
// Sleep mode decode, clock gating and wake-up sequencing
`timescale 1ns/100ps
`include "sleep_ctl_cfg.svh"

module sleep_mode_power_controller #(
	parameter logic [15:0] DLY2_CYCLES = 16'(`DLY2_CYCLES),
	parameter logic [15:0] DLY3_CYCLES = 16'(`DLY3_CYCLES)
) (
	// Clock, reset, enable
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	// Core sleep request
	input wire logic sleep_arm_bit_in,
	input wire logic [2:0] sleep_mode_select_in,
	input wire logic sleep_exec_in,
	input wire logic core_irq_in,
	input wire logic global_irq_en_in,
	// Fuses
	input wire logic [3:0] clock_source_fuses_in,
	input wire logic [2:0] brownout_threshold_fuses_in,
	input wire logic debug_enable_fuse_in,
	input wire logic boundary_port_enable_fuse_in,
	input wire logic boundary_port_disable_bit_in,
	// Asynchronous wake sources
	input wire logic ext_reset_in,
	input wire logic wdt_reset_in,
	input wire logic wdt_irq_in,
	input wire logic brownout_reset_in,
	input wire logic two_wire_match_in,
	input wire logic ext_level_irq_in,
	input wire logic pin_change_irq_in,
	input wire logic timer_two_ovf_in,
	input wire logic timer_two_cmp_in,
	// Timer two setup
	input wire logic [1:0] timer_two_irq_mask_in,
	input wire logic timer_two_enable_in,
	input wire logic timer_two_async_in,
	// Peripheral setup
	input wire logic [7:0] peripheral_clock_gate_reg_in,
	input wire logic adc_enable_in,
	input wire logic adc_conv_start_in,
	input wire logic comparator_enable_in,
	input wire logic comparator_uses_ref_in,
	input wire logic wdt_enable_in,
	// Clock domain enables
	output logic cpu_clk_en_out,
	output logic flash_clk_en_out,
	output logic io_clk_en_out,
	output logic adc_clk_en_out,
	output logic async_clk_en_out,
	output logic main_osc_en_out,
	output logic timer_osc_en_out,
	output logic timer_two_sync_clk_en_out,
	output logic [7:0] periph_clk_en_out,
	output logic [7:0] periph_access_en_out,
	// Analog and support blocks
	output logic adc_keep_on_out,
	output logic adc_extended_conv_out,
	output logic comparator_en_out,
	output logic vref_en_out,
	output logic brownout_en_out,
	output logic wdt_run_out,
	output logic input_buf_en_out,
	output logic debug_en_out,
	// Core status
	output logic core_hold_out,
	output logic irq_deliver_out,
	output logic reset_wake_out,
	output logic sleeping_out
);

	sleep_ctl_pkg::pm_state_t state_reg;
	sleep_ctl_pkg::pm_state_t state_next;
	logic [15:0] cnt_reg;
	logic [15:0] cnt_next;
	logic [2:0] mode_reg;
	logic [2:0] mode_next;
	logic lvl_only_reg;
	logic lvl_only_next;
	logic irq_ok_reg;
	logic irq_ok_next;
	logic rst_wake_reg;
	logic rst_wake_next;
	logic irq_pulse_reg;
	logic irq_pulse_next;
	logic rst_pulse_reg;
	logic rst_pulse_next;
	logic ext_conv_reg;
	logic adc_en_d_reg;
	logic [`WAKE_N-1:0] sync1_reg;
	logic [`WAKE_N-1:0] sync2_reg;

	// Two-stage synchronisers on every asynchronous wake pin
	wire [`WAKE_N-1:0] wake_raw = {
		ext_reset_in,
		wdt_reset_in,
		brownout_reset_in,
		wdt_irq_in,
		two_wire_match_in,
		ext_level_irq_in,
		pin_change_irq_in,
		timer_two_ovf_in,
		timer_two_cmp_in
	};

	genvar gi;
	generate
		for (gi = 0; gi < `WAKE_N; gi = gi + 1) begin : g_sync
			always_ff @(posedge sys_clk_in) begin
				if (sys_rst_in) begin
					sync1_reg[gi] <= 1'b0;
					sync2_reg[gi] <= 1'b0;
				end else if (clk_en_in) begin
					sync1_reg[gi] <= wake_raw[gi];
					sync2_reg[gi] <= sync1_reg[gi];
				end
			end
		end
	endgenerate

	wire ext_rst_s = sync2_reg[8];
	wire wdt_rst_s = sync2_reg[7];
	wire bor_s = sync2_reg[6];
	wire wdt_irq_s = sync2_reg[5];
	wire addr_match_s = sync2_reg[4];
	wire ext_lvl_s = sync2_reg[3];
	wire pin_chg_s = sync2_reg[2];
	wire t2_ovf_s = sync2_reg[1];
	wire t2_cmp_s = sync2_reg[0];

	// Mode decode
	wire xtal_clk = clock_source_fuses_in[3];
	wire m_idle = (mode_reg == `MODE_IDLE);
	wire m_pdown = (mode_reg == `MODE_PDOWN);
	wire m_psave = (mode_reg == `MODE_PSAVE);
	wire m_sby = (mode_reg == `MODE_SBY);
	wire m_xsby = (mode_reg == `MODE_XSBY);
	wire m_timer_kept = m_psave | m_xsby;
	wire m_osc_kept = m_sby | m_xsby;

	// Codes 001, 100, 101 and Standby without a crystal are ignored
	wire sel_ok =
		(sleep_mode_select_in == `MODE_IDLE) |
		(sleep_mode_select_in == `MODE_PDOWN) |
		(sleep_mode_select_in == `MODE_PSAVE) |
		(((sleep_mode_select_in == `MODE_SBY) |
		(sleep_mode_select_in == `MODE_XSBY)) & xtal_clk);

	// The sleep instruction without the arm bit is a no-op
	wire sleep_go = sleep_exec_in & sleep_arm_bit_in & sel_ok;

	// Wake source qualification
	wire wake_rst = ext_rst_s | wdt_rst_s | bor_s;
	wire deep_irq = wdt_irq_s | addr_match_s | ext_lvl_s | pin_chg_s;
	wire t2_evt = timer_two_enable_in & global_irq_en_in &
		((t2_ovf_s & timer_two_irq_mask_in[0]) |
		(t2_cmp_s & timer_two_irq_mask_in[1]));
	wire wake_irq =
		m_idle ? (core_irq_in | deep_irq | t2_evt) :
		m_timer_kept ? (deep_irq | t2_evt) : deep_irq;
	wire lvl_only = ext_lvl_s & ~(wdt_irq_s | addr_match_s |
		pin_chg_s | t2_evt | (m_idle & core_irq_in));

	// Stabilisation delay chosen by the clock source fuses
	wire [15:0] fuse_dly =
		(clock_source_fuses_in[1:0] == 2'h0) ? `DLY0_CYCLES :
		(clock_source_fuses_in[1:0] == 2'h1) ? `DLY1_CYCLES :
		(clock_source_fuses_in[1:0] == 2'h2) ? DLY2_CYCLES :
		DLY3_CYCLES;

	// Standby keeps the oscillator, so only a short count is needed
	wire [15:0] wake_dly = m_osc_kept ? `SBY_WAKE_CYCLES : fuse_dly;

	wire cnt_last = (cnt_reg == 16'h0001);
	wire [15:0] cnt_dec = cnt_reg - 16'h0001;

	// Sequencer
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		mode_next = mode_reg;
		lvl_only_next = lvl_only_reg;
		irq_ok_next = irq_ok_reg;
		rst_wake_next = rst_wake_reg;
		irq_pulse_next = 1'b0;
		rst_pulse_next = 1'b0;
		case (state_reg)
			sleep_ctl_pkg::ST_ACTIVE: begin
				if (sleep_go) begin
					mode_next = sleep_mode_select_in;
					state_next = sleep_ctl_pkg::ST_SLEEP;
				end
			end
			sleep_ctl_pkg::ST_SLEEP: begin
				if (wake_rst | wake_irq) begin
					rst_wake_next = wake_rst;
					lvl_only_next = ~wake_rst & lvl_only;
					irq_ok_next = 1'b1;
					if (m_idle) begin
						// Idle keeps the oscillator and I/O clocks running, no start-up needed
						if (wake_rst) begin
							state_next = sleep_ctl_pkg::ST_ACTIVE;
							rst_pulse_next = 1'b1;
						end else begin
							state_next = sleep_ctl_pkg::ST_HOLD;
							cnt_next = `HOLD_CYCLES;
						end
					end else begin
						state_next = sleep_ctl_pkg::ST_START;
						cnt_next = wake_dly;
					end
				end
			end
			sleep_ctl_pkg::ST_START: begin
				cnt_next = cnt_dec;
				if (cnt_last) begin
					if (rst_wake_reg) begin
						state_next = sleep_ctl_pkg::ST_ACTIVE;
						rst_pulse_next = 1'b1;
					end else if (lvl_only_reg & ~ext_lvl_s) begin
						// Level gone before start-up ended: wake, no irq
						state_next = sleep_ctl_pkg::ST_ACTIVE;
						irq_ok_next = 1'b0;
					end else begin
						state_next = sleep_ctl_pkg::ST_HOLD;
						cnt_next = `HOLD_CYCLES;
					end
				end
			end
			sleep_ctl_pkg::ST_HOLD: begin
				cnt_next = cnt_dec;
				if (cnt_last) begin
					state_next = sleep_ctl_pkg::ST_ACTIVE;
					irq_pulse_next = irq_ok_reg;
				end
			end
			default: begin
				state_next = sleep_ctl_pkg::ST_ACTIVE;
				cnt_next = 16'h0000;
			end
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			state_reg <= sleep_ctl_pkg::ST_ACTIVE;
			cnt_reg <= 16'h0000;
			mode_reg <= 3'h0;
			lvl_only_reg <= 1'b0;
			irq_ok_reg <= 1'b0;
			rst_wake_reg <= 1'b0;
			irq_pulse_reg <= 1'b0;
			rst_pulse_reg <= 1'b0;
		end else if (clk_en_in) begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			mode_reg <= mode_next;
			lvl_only_reg <= lvl_only_next;
			irq_ok_reg <= irq_ok_next;
			rst_wake_reg <= rst_wake_next;
			irq_pulse_reg <= irq_pulse_next;
			rst_pulse_reg <= rst_pulse_next;
		end
	end

	// Clock domain plan, computed ahead and registered
	wire st_active = (state_next == sleep_ctl_pkg::ST_ACTIVE);
	wire st_hold = (state_next == sleep_ctl_pkg::ST_HOLD);
	wire st_asleep = ~st_active & ~st_hold;
	wire nm_idle = (mode_next == `MODE_IDLE);
	wire nm_timer = (mode_next == `MODE_PSAVE) | (mode_next == `MODE_XSBY);
	wire nm_osc = (mode_next == `MODE_SBY) | (mode_next == `MODE_XSBY);
	wire awake = st_active | st_hold;
	wire idle_sleep = st_asleep & nm_idle;
	wire deep_sleep = st_asleep & ~nm_idle;

	// CPU stays gated through the whole start-up and hold
	wire cpu_en_n = st_active;
	wire io_en_n = awake | idle_sleep;
	wire t2_kept = deep_sleep & nm_timer & timer_two_enable_in;
	wire t2_sync_n = (awake | idle_sleep) |
		(t2_kept & ~timer_two_async_in);
	wire async_en_n = awake | idle_sleep |
		(t2_kept & timer_two_async_in);
	wire tosc_en_n = timer_two_async_in &
		(awake | idle_sleep | t2_kept);
	wire dbg_en = debug_enable_fuse_in & boundary_port_enable_fuse_in &
		~boundary_port_disable_bit_in;
	// A timer on the sync clock still needs the main oscillator
	wire osc_en_n = awake | idle_sleep | (deep_sleep & nm_osc) |
		(t2_kept & ~timer_two_async_in) | debug_enable_fuse_in;
	// Gate bits matter to the peripheral clocks only while the I/O clock runs at all; access enables follow them always
	wire [7:0] pclk_n = {8{io_en_n}} &
		~peripheral_clock_gate_reg_in;
	wire [7:0] pacc_n = ~peripheral_clock_gate_reg_in;
	wire cmp_en_n = comparator_enable_in & ~deep_sleep;
	wire bod_on = (brownout_threshold_fuses_in != `BROWNOUT_OFF_CODE);
	wire vref_n = bod_on | adc_enable_in |
		(comparator_enable_in & comparator_uses_ref_in);
	wire inbuf_n = io_en_n;

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			cpu_clk_en_out <= 1'b1;
			flash_clk_en_out <= 1'b1;
			io_clk_en_out <= 1'b1;
			adc_clk_en_out <= 1'b1;
			async_clk_en_out <= 1'b1;
			main_osc_en_out <= 1'b1;
			timer_osc_en_out <= 1'b0;
			timer_two_sync_clk_en_out <= 1'b1;
			periph_clk_en_out <= 8'hff;
			periph_access_en_out <= 8'hff;
			comparator_en_out <= 1'b0;
			vref_en_out <= 1'b0;
			brownout_en_out <= 1'b0;
			wdt_run_out <= 1'b0;
			adc_keep_on_out <= 1'b0;
			input_buf_en_out <= 1'b1;
			debug_en_out <= 1'b0;
		end else if (clk_en_in) begin
			cpu_clk_en_out <= cpu_en_n;
			flash_clk_en_out <= cpu_en_n;
			io_clk_en_out <= io_en_n;
			adc_clk_en_out <= io_en_n;
			async_clk_en_out <= async_en_n;
			main_osc_en_out <= osc_en_n;
			timer_osc_en_out <= tosc_en_n;
			timer_two_sync_clk_en_out <= t2_sync_n;
			periph_clk_en_out <= pclk_n;
			periph_access_en_out <= pacc_n;
			comparator_en_out <= cmp_en_n;
			vref_en_out <= vref_n;
			brownout_en_out <= bod_on;
			wdt_run_out <= wdt_enable_in;
			adc_keep_on_out <= adc_enable_in;
			input_buf_en_out <= inbuf_n;
			debug_en_out <= dbg_en;
		end
	end

	// Converter re-enable tracking; a new switch-off wins over a start
	wire adc_off_edge = adc_en_d_reg & ~adc_enable_in;
	wire ext_conv_clr = adc_conv_start_in & adc_enable_in;

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			adc_en_d_reg <= 1'b0;
			ext_conv_reg <= 1'b1;
		end else if (clk_en_in) begin
			adc_en_d_reg <= adc_enable_in;
			if (adc_off_edge) begin
				ext_conv_reg <= 1'b1;
			end else if (ext_conv_clr) begin
				ext_conv_reg <= 1'b0;
			end
		end
	end

	assign adc_extended_conv_out = ext_conv_reg;
	assign core_hold_out = (state_reg != sleep_ctl_pkg::ST_ACTIVE);
	assign irq_deliver_out = irq_pulse_reg;
	assign reset_wake_out = rst_pulse_reg;
	assign sleeping_out = (state_reg == sleep_ctl_pkg::ST_SLEEP);

endmodule : sleep_mode_power_controller

// *** test/smpc_properties.sv ***
// Port assertions for the sleep mode power controller
`timescale 1ns/100ps
module smpc_properties (
	input wire logic sys_clk_in, sys_rst_in, clk_en_in,
	input wire logic sleep_arm_bit_in, sleep_exec_in,
	input wire logic [2:0] sleep_mode_select_in,
	input wire logic [2:0] brownout_threshold_fuses_in,
	input wire logic debug_enable_fuse_in, boundary_port_enable_fuse_in,
	input wire logic boundary_port_disable_bit_in, wdt_enable_in,
	input wire logic adc_enable_in, comparator_enable_in,
	input wire logic comparator_uses_ref_in,
	input wire logic [7:0] peripheral_clock_gate_reg_in,
	input wire logic [7:0] periph_clk_en_out, periph_access_en_out,
	input wire logic cpu_clk_en_out, io_clk_en_out, main_osc_en_out,
	input wire logic input_buf_en_out, debug_en_out, brownout_en_out,
	input wire logic wdt_run_out, adc_keep_on_out, vref_en_out,
	input wire logic core_hold_out, sleeping_out, irq_deliver_out,
	input wire logic reset_wake_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);
	wire brownout_on = brownout_threshold_fuses_in != 3'h7;
	AST_ENTER_PDOWN: assert property (
		clk_en_in && !core_hold_out && sleep_exec_in && sleep_arm_bit_in &&
		sleep_mode_select_in == 3'h2 && !debug_enable_fuse_in |=>
		sleeping_out && !io_clk_en_out && !main_osc_en_out)
		else $error("power-down entry wrong");
	AST_CPU_HALT: assert property (core_hold_out |-> !cpu_clk_en_out)
		else $error("cpu clock runs while held");
	AST_WAKE_HOLD: assert property (
		irq_deliver_out |-> $past(core_hold_out) && $past(core_hold_out, 4)
		&& !core_hold_out)
		else $error("handler without four held cycles");
	AST_DEBUG: assert property (
		clk_en_in |=> debug_en_out == $past(debug_enable_fuse_in &
		boundary_port_enable_fuse_in & !boundary_port_disable_bit_in))
		else $error("debug enable wrong");
	AST_OSC_DEBUG: assert property (
		clk_en_in && debug_enable_fuse_in |=> main_osc_en_out)
		else $error("oscillator off with debug fuse");
	AST_BROWNOUT: assert property (
		clk_en_in |=> brownout_en_out == $past(brownout_on))
		else $error("brownout enable wrong");
	AST_WDT: assert property (
		clk_en_in |=> wdt_run_out == $past(wdt_enable_in))
		else $error("watchdog run flag wrong");
	AST_ADC_KEEP: assert property (
		clk_en_in |=> adc_keep_on_out == $past(adc_enable_in))
		else $error("converter keep flag wrong");
	AST_VREF: assert property (
		clk_en_in |=> vref_en_out == $past(brownout_on | adc_enable_in |
		comparator_enable_in & comparator_uses_ref_in))
		else $error("reference enable wrong");
	AST_ACCESS: assert property (
		clk_en_in |=> periph_access_en_out == ~$past(peripheral_clock_gate_reg_in))
		else $error("peripheral access wrong");
	AST_PCLK: assert property (
		periph_clk_en_out == (periph_access_en_out & {8{io_clk_en_out}}))
		else $error("peripheral clock wrong");
	AST_BUF: assert property (input_buf_en_out == io_clk_en_out)
		else $error("input buffers wrong");
	cover property ($rose(sleeping_out));
	cover property (irq_deliver_out);
	cover property (reset_wake_out);
endmodule : smpc_properties
bind sleep_mode_power_controller smpc_properties smpc_properties_i (.*);

// *** test/core_model.sv ***
// Processor core model that arms sleep and issues the sleep instruction
`timescale 1ns/100ps
module core_model (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Bench requests
	input wire logic go_in,
	input wire logic arm_in,
	input wire logic [2:0] mode_in,
	input wire logic awake_in,
	// Towards the controller
	output logic arm_out,
	output logic [2:0] mode_out,
	output logic exec_out
);
	logic go_reg;
	// Arm comes one cycle before the instruction, cleared after a wake that delivers an interrupt or a reset
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			go_reg <= 1'b0;
			arm_out <= 1'b0;
			mode_out <= 3'h0;
			exec_out <= 1'b0;
		end else begin
			go_reg <= go_in;
			exec_out <= go_reg;
			arm_out <= go_in ? arm_in : arm_out & ~awake_in;
			if (go_in) mode_out <= mode_in;
		end
	end
endmodule : core_model

// *** test/sleep_mode_power_controller_tb.sv ***
// Self-checking bench for the sleep mode power controller
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("unexpected %s: expected %h, seen %h", nm, e, g); end end
module sleep_mode_power_controller_tb;
	logic sys_clk_in, sys_rst_in, clk_en_in, sleep_arm_bit_in, sleep_exec_in;
	logic [2:0] sleep_mode_select_in, brownout_threshold_fuses_in, mode;
	logic [3:0] clock_source_fuses_in;
	logic [1:0] timer_two_irq_mask_in;
	logic [7:0] peripheral_clock_gate_reg_in, periph_clk_en_out;
	logic [7:0] periph_access_en_out;
	logic [9:0] src;
	logic core_irq_in, global_irq_en_in, debug_enable_fuse_in;
	logic boundary_port_enable_fuse_in, boundary_port_disable_bit_in;
	logic ext_reset_in, wdt_reset_in, wdt_irq_in, brownout_reset_in;
	logic two_wire_match_in, ext_level_irq_in, pin_change_irq_in;
	logic timer_two_ovf_in, timer_two_cmp_in, timer_two_enable_in;
	logic timer_two_async_in, adc_enable_in, adc_conv_start_in;
	logic comparator_enable_in, comparator_uses_ref_in, wdt_enable_in;
	logic cpu_clk_en_out, flash_clk_en_out, io_clk_en_out, adc_clk_en_out;
	logic async_clk_en_out, main_osc_en_out, timer_osc_en_out;
	logic timer_two_sync_clk_en_out, adc_keep_on_out, adc_extended_conv_out;
	logic comparator_en_out, vref_en_out, brownout_en_out, wdt_run_out;
	logic input_buf_en_out, debug_en_out, core_hold_out, irq_deliver_out;
	logic reset_wake_out, sleeping_out, go, arm;
	logic [2:0] md [4] = '{3'h2, 3'h3, 3'h6, 3'h7};
	logic [3:0] ck [4] = '{4'h0, 4'ha, 4'h4, 4'he};
	int wb [4] = '{6, 7, 4, 8};
	int ex [4] = '{28, 28, 14, 14};
	int n_errors = 0, n_checks = 0, cyc = 0, n, d, r;
	assign {core_irq_in, timer_two_cmp_in, timer_two_ovf_in, pin_change_irq_in,
		ext_level_irq_in, two_wire_match_in, brownout_reset_in, wdt_irq_in,
		wdt_reset_in, ext_reset_in} = src;
	// Fuse delay index 2 shortened so power-down wakes stay quick
	sleep_mode_power_controller #(.DLY2_CYCLES(16'h0014))
		sleep_mode_power_controller_i (.*);
	core_model core_model_i (.clk_in(sys_clk_in), .rst_in(sys_rst_in),
		.go_in(go), .arm_in(arm), .mode_in(mode),
		.awake_in(irq_deliver_out | reset_wake_out), .arm_out(sleep_arm_bit_in),
		.mode_out(sleep_mode_select_in), .exec_out(sleep_exec_in));
	initial begin
		sys_clk_in = 1'b0;
		forever #50 sys_clk_in = ~sys_clk_in;
	end
	always @(posedge sys_clk_in) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			stop_test();
		end
	end
	task stop_test();
		$display("checks %0d, errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : stop_test
	task enter(input logic [2:0] m, input logic a);
		mode = m;
		arm = a;
		go = 1'b1;
		@(negedge sys_clk_in);
		go = 1'b0;
		repeat (3) @(negedge sys_clk_in);
	endtask : enter
	// A wake source dropped early shows whether the interrupt is withheld
	task wake(input int b, input int hold);
		src[b] = 1'b1;
		n = 0;
		d = 0;
		r = 0;
		while (core_hold_out !== 1'b0 && n < 400) begin
			@(negedge sys_clk_in);
			n++;
			if (n == hold) src[b] = 1'b0;
			d += irq_deliver_out;
			r += reset_wake_out;
		end
		src[b] = 1'b0;
		repeat (3) @(negedge sys_clk_in);
	endtask : wake
	initial begin
		sys_rst_in = 1'b1;
		clk_en_in = 1'b1;
		go = 1'b0;
		arm = 1'b0;
		mode = 3'h0;
		src = 10'h000;
		global_irq_en_in = 1'b1;
		clock_source_fuses_in = 4'ha;
		brownout_threshold_fuses_in = 3'h4;
		debug_enable_fuse_in = 1'b0;
		boundary_port_enable_fuse_in = 1'b1;
		boundary_port_disable_bit_in = 1'b0;
		timer_two_irq_mask_in = 2'h0;
		timer_two_enable_in = 1'b1;
		timer_two_async_in = 1'b1;
		peripheral_clock_gate_reg_in = 8'h81;
		adc_enable_in = 1'b1;
		adc_conv_start_in = 1'b0;
		comparator_enable_in = 1'b1;
		comparator_uses_ref_in = 1'b0;
		wdt_enable_in = 1'b1;
		repeat (2) @(negedge sys_clk_in);
		sys_rst_in = 1'b0;
		`CHK("extended after reset", 1'b1, adc_extended_conv_out)
		adc_conv_start_in = 1'b1;
		@(negedge sys_clk_in);
		adc_conv_start_in = 1'b0;
		@(negedge sys_clk_in);
		`CHK("extended cleared", 1'b0, adc_extended_conv_out)
		`CHK("gated clocks", 8'h7e, periph_clk_en_out)
		enter(3'h2, 1'b0);
		`CHK("unarmed sleep", 1'b0, sleeping_out)
		enter(3'h4, 1'b1);
		`CHK("reserved code", 1'b0, sleeping_out)
		clock_source_fuses_in = 4'h2;
		enter(3'h6, 1'b1);
		`CHK("standby without crystal", 1'b0, sleeping_out)
		clock_source_fuses_in = 4'ha;
		enter(3'h0, 1'b1);
		`CHK("idle core clocks", 2'h0, {cpu_clk_en_out, flash_clk_en_out})
		`CHK("idle clocks", 4'hf, {io_clk_en_out, adc_clk_en_out,
			async_clk_en_out, main_osc_en_out})
		`CHK("idle gating", 9'h17e, {comparator_en_out, periph_clk_en_out})
		// A reset source seen while the enable is low must not move anything
		clk_en_in = 1'b0;
		src[0] = 1'b1;
		repeat (4) @(negedge sys_clk_in);
		`CHK("frozen idle", 2'h2, {sleeping_out, cpu_clk_en_out})
		src[0] = 1'b0;
		clk_en_in = 1'b1;
		@(negedge sys_clk_in);
		wake(9, 0);
		`CHK("idle wake cycles", n inside {[5:7]}, 1'b1)
		`CHK("idle handler", 2'h3, {d == 1, cpu_clk_en_out})
		for (int i = 0; i < 4; i++) begin
			timer_two_irq_mask_in = 2'h0;
			enter(md[i], 1'b1);
			`CHK("deep clocks", ck[i], {async_clk_en_out, main_osc_en_out,
				timer_osc_en_out, timer_two_sync_clk_en_out})
			`CHK("deep gates", 15'h0007, {io_clk_en_out, adc_clk_en_out,
				input_buf_en_out, comparator_en_out, periph_clk_en_out,
				wdt_run_out, brownout_en_out, adc_keep_on_out})
			src[7] = 1'b1;
			repeat (40) @(negedge sys_clk_in);
			src[7] = 1'b0;
			repeat (4) @(negedge sys_clk_in);
			`CHK("masked timer", 1'b1, sleeping_out)
			timer_two_irq_mask_in = 2'h3;
			wake(wb[i], 0);
			`CHK("deep wake cycles", n inside {[ex[i] - 1:ex[i] + 1]}, 1'b1)
			`CHK("deep handler", 1'b1, d == 1)
		end
		// Timer on the synchronous clock keeps the oscillator, not the crystal
		timer_two_async_in = 1'b0;
		enter(3'h3, 1'b1);
		`CHK("sync timer clocks", 4'h5, {async_clk_en_out, main_osc_en_out,
			timer_osc_en_out, timer_two_sync_clk_en_out})
		wake(7, 0);
		`CHK("sync timer wake", 1'b1, d == 1)
		timer_two_async_in = 1'b1;
		enter(3'h2, 1'b1);
		wake(5, 3);
		`CHK("short level wake", 2'h0, {core_hold_out, d != 0})
		enter(3'h2, 1'b1);
		wake(5, 0);
		`CHK("held level wake", 1'b1, d == 1)
		enter(3'h6, 1'b1);
		wake(0, 0);
		`CHK("reset wake", 2'h2, {r == 1, d != 0})
		debug_enable_fuse_in = 1'b1;
		enter(3'h2, 1'b1);
		`CHK("debug keeps oscillator", 2'h3, {main_osc_en_out, debug_en_out})
		wake(2, 0);
		boundary_port_disable_bit_in = 1'b1;
		brownout_threshold_fuses_in = 3'h7;
		adc_enable_in = 1'b0;
		repeat (2) @(negedge sys_clk_in);
		`CHK("debug off", 1'b0, debug_en_out)
		`CHK("reference off", 3'h1, {vref_en_out, brownout_en_out,
			adc_extended_conv_out})
		comparator_uses_ref_in = 1'b1;
		repeat (2) @(negedge sys_clk_in);
		`CHK("reference for comparator", 1'b1, vref_en_out)
		stop_test();
	end
endmodule : sleep_mode_power_controller_tb
